//--- osc_ctrl_props.sv
// Port-level assertions for the oscillator select control block
`timescale 1ns/1ps
`default_nettype none

module osc_ctrl_props (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic wb_ack_o, // Bus acknowledge
  input wire logic [23:0] cfg_fuse_word, // Configuration word
  input wire logic clock_fail_detect, // Failure event
  input wire logic switch_done, // Switch finished
  input wire logic [2:0] current_group, // Active group
  input wire logic [2:0] switch_target, // Requested group
  input wire logic switch_request, // Switch pending
  input wire logic switch_abort, // Abort pulse
  input wire logic clock_fail_flag, // Sticky fail flag
  input wire logic [3:0] rc_trim_field, // Trim code
  input wire logic switch_enabled, // Switching allowed
  input wire logic failsafe_clock_monitor // Monitor enabled
);
  ////////////////////////////////////////////////////////////////////////////
  // Helpers: any bus write, and a failure the monitor acts on
  wire bus_wr = wb_cyc_i && wb_stb_i && wb_we_i; // Write request on bus
  wire fail_ev = clock_fail_detect && failsafe_clock_monitor; // Effective failure

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers one cycle after taking, and only for one cycle
  ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack late or held");
  // Both group fields load from the word at the first edge after reset
  poweron_groups_a: assert property ($rose(reset_n) |=>
    current_group == $past(cfg_fuse_word[10:8]) && switch_target == current_group)
    else $error("groups not loaded from config");
  // Completed switch copies the target into the current group
  switch_loads_a: assert property (switch_request && switch_done && !fail_ev |=>
    current_group == $past(switch_target))
    else $error("switch did not load group");
  // Failure forces fast RC, sets flag and drops the request
  fail_forces_a: assert property (fail_ev |=>
    current_group == 3'h1 && clock_fail_flag && !switch_request)
    else $error("failure response wrong");
  // Request stays up while nothing can end it
  request_held_a: assert property (switch_request && !switch_done && !clock_fail_detect && !bus_wr |=>
    switch_request)
    else $error("request dropped alone");
  // Abort is a single pulse with the request already gone
  abort_pulse_a: assert property (switch_abort |-> !switch_request ##1 !switch_abort)
    else $error("abort pulse wrong");
  // Flag only clears through a bus write
  flag_sticky_a: assert property (clock_fail_flag && !bus_wr |=> clock_fail_flag)
    else $error("flag cleared alone");
  // Trim and target move only on bus writes, target also on the config load after reset
  trim_stable_a: assert property (!bus_wr |=> $stable(rc_trim_field))
    else $error("trim changed without write");
  target_stable_a: assert property (!bus_wr && !$rose(reset_n) |=> $stable(switch_target))
    else $error("target changed without write");
  // Monitor on implies switching on, never the reverse
  monitor_needs_switch_a: assert property (failsafe_clock_monitor |-> switch_enabled)
    else $error("monitor without switching");
endmodule

bind osc_select_ctrl osc_ctrl_props i_osc_ctrl_props (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .cfg_fuse_word, .clock_fail_detect, .switch_done, .current_group,
  .switch_target, .switch_request, .switch_abort, .clock_fail_flag, .rc_trim_field,
  .switch_enabled, .failsafe_clock_monitor);

`default_nettype wire

//--- osc_pkg.sv
// Constants and types shared by the oscillator select control block
// Function
// - Unlocked byte accepts exactly one following write
// - Current group field reports active clock source
// - Power-on loads both group fields from configuration
// - Completed switch copies new group to current
// - Clock failure forces current group to fast RC
// - Writable new group field holds switch target
// - Postscaler divides by 1, 4, 16, 64
// - Lock bit mirrors PLL lock state
// - Clock failure sets flag; software may clear
// - Bit one enables the secondary oscillator
// - Switch request bit held until switch completes
// - Unimplemented bits always read as zero
// - Four bit trim field tunes fast RC
// - Config bits 15-14 gate switching and monitor
// - Config bits 10-8 select power-on group
// - Config bits 4-0 select primary option
// - Power-on selects clock source from configuration
// - Clock failure also clears the switch request
// - Clearing request mid-switch aborts the transition
`default_nettype none

package osc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses on the bus
  localparam logic [7:0] OSC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] OSC_ADDR_TUNE = 8'h04;
  localparam logic [7:0] OSC_ADDR_CFG = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Unlock keys, low byte pair then high byte pair
  localparam logic [7:0] OSC_KEY_LO_FIRST = 8'h46;
  localparam logic [7:0] OSC_KEY_LO_SECOND = 8'h57;
  localparam logic [7:0] OSC_KEY_HI_FIRST = 8'h78;
  localparam logic [7:0] OSC_KEY_HI_SECOND = 8'h9a;

  ////////////////////////////////////////////////////////////////////////////
  // Control register field positions
  localparam int OSC_CUR_LSB = 12;
  localparam int OSC_NEW_LSB = 8;
  localparam int OSC_POST_LSB = 6;
  localparam int OSC_LOCK_BIT = 5;
  localparam int OSC_CF_BIT = 3;
  localparam int OSC_SEC_EN_BIT = 1;
  localparam int OSC_REQ_BIT = 0;

  // Configuration word field positions and implemented-bit mask
  localparam int OSC_CFG_SWMON_LSB = 14;
  localparam int OSC_CFG_GROUP_LSB = 8;
  localparam logic [23:0] OSC_CFG_MASK = 24'h00c71f;

  ////////////////////////////////////////////////////////////////////////////
  // Group codes
  localparam logic [2:0] OSC_GRP_SEC_XTAL = 3'h0;
  localparam logic [2:0] OSC_GRP_FAST_RC = 3'h1;
  localparam logic [2:0] OSC_GRP_LOW_RC = 3'h2;
  localparam logic [2:0] OSC_GRP_PRIMARY = 3'h3;
  localparam logic [2:0] OSC_GRP_PLL = 3'h7;

  // Reset values
  localparam logic [1:0] OSC_POST_RESET = 2'h0;
  localparam logic [3:0] OSC_TRIM_RESET = 4'h0;

  // Postscaler terminal counts (divide minus one)
  localparam logic [5:0] OSC_DIV1_LAST = 6'h00;
  localparam logic [5:0] OSC_DIV4_LAST = 6'h03;
  localparam logic [5:0] OSC_DIV16_LAST = 6'h0f;
  localparam logic [5:0] OSC_DIV64_LAST = 6'h3f;

  ////////////////////////////////////////////////////////////////////////////
  // Per-byte unlock sequencer state
  typedef enum logic [1:0] {
    OSC_LK_IDLE = 2'b00,
    OSC_LK_KEY1 = 2'b01,
    OSC_LK_OPEN = 2'b10
  } osc_lock_t;

endpackage

`default_nettype wire

//--- osc_select_ctrl.sv
// Oscillator select control: protected control register, trim, config, postscaler
`timescale 1ns/1ps
`default_nettype none

module osc_select_ctrl (
  input wire logic sys_clk, // System clock, 200 MHz
  input wire logic reset_n, // Power-on / brown-out reset, async active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [23:0] cfg_fuse_word, // Non-volatile configuration word
  input wire logic pll_locked, // PLL lock level
  input wire logic clock_fail_detect, // Fail-safe monitor failure pulse
  input wire logic switch_done, // Analog switch finished pulse
  output logic [2:0] current_group, // Active oscillator group
  output logic [2:0] switch_target, // Requested group
  output logic switch_request, // Switch in progress
  output logic switch_abort, // One-cycle abort pulse
  output logic clock_fail_flag, // Sticky clock-fail flag
  output logic secondary_osc_enable, // 32 kHz oscillator enable
  output logic [3:0] rc_trim_field, // Fast RC trim code
  output logic [4:0] primary_option_config, // Option inside primary group
  output logic switch_enabled, // Clock switching allowed
  output logic failsafe_clock_monitor, // Fail-safe monitor enabled
  output logic postscaled_tick // One pulse per postscaled period
);

  ////////////////////////////////////////////////////////////////////////////
  // Postscaler select to terminal count (divide minus one)
  function automatic logic [5:0] post_last(input logic [1:0] sel);
    case (sel)
      2'b11: post_last = osc_pkg::OSC_DIV64_LAST;
      2'b10: post_last = osc_pkg::OSC_DIV16_LAST;
      2'b01: post_last = osc_pkg::OSC_DIV4_LAST;
      default: post_last = osc_pkg::OSC_DIV1_LAST;
    endcase
  endfunction

  // True when a bus write hits one byte lane of the control register alone
  function automatic logic lane_only(input logic [3:0] sel, input int lane);
    lane_only = (sel == (4'h1 << lane));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic ack_reg; // Bus acknowledge
  logic [31:0] rdata_reg; // Registered read data
  logic cfg_loaded_reg; // Config word captured after reset
  logic [23:0] config_reg; // Captured configuration word
  logic [2:0] current_reg; // Current group
  logic [2:0] new_reg; // New group
  logic [1:0] post_reg; // Postscaler select
  logic cf_reg; // Clock-fail flag
  logic sec_en_reg; // Secondary oscillator enable
  logic req_reg; // Switch request
  logic abort_reg; // Abort pulse
  logic [3:0] trim_reg; // Fast RC trim
  logic [5:0] post_cnt_reg; // Postscaler counter
  logic tick_reg; // Postscaler output tick

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire access_fire = wb_cyc_i & wb_stb_i & ~ack_reg; // One per bus access
  wire wr_fire = access_fire & wb_we_i;
  wire hit_ctrl = (wb_adr_i == osc_pkg::OSC_ADDR_CTRL);
  wire hit_tune = (wb_adr_i == osc_pkg::OSC_ADDR_TUNE);
  wire hit_cfg = (wb_adr_i == osc_pkg::OSC_ADDR_CFG);

  ////////////////////////////////////////////////////////////////////////////
  // Per-byte unlock sequencers; lane 0 is the low byte, lane 1 the high byte
  logic [1:0] lane_wr; // Single-lane write to the control register
  logic [1:0] lane_open; // Unlock window open on this lane
  logic [7:0] lane_data [2]; // Write data of each lane

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lock
      localparam logic [7:0] KEY_FIRST = (g == 0) ? osc_pkg::OSC_KEY_LO_FIRST : osc_pkg::OSC_KEY_HI_FIRST;
      localparam logic [7:0] KEY_SECOND = (g == 0) ? osc_pkg::OSC_KEY_LO_SECOND : osc_pkg::OSC_KEY_HI_SECOND;
      osc_pkg::osc_lock_t lock_reg; // Sequencer state
      osc_pkg::osc_lock_t lock_next; // Next state

      assign lane_data[g] = wb_dat_i[8*g +: 8];
      assign lane_wr[g] = wr_fire & hit_ctrl & lane_only(wb_sel_i, g);
      assign lane_open[g] = (lock_reg == osc_pkg::OSC_LK_OPEN);

      // Every bus access advances the sequencer, so any access between the
      // two keys other than a repeated first key, or after the window, drops back to idle
      always_comb begin
        lock_next = lock_reg;
        if (access_fire) begin
          case (lock_reg)
            osc_pkg::OSC_LK_IDLE: begin
              lock_next = (lane_wr[g] && lane_data[g] == KEY_FIRST) ? osc_pkg::OSC_LK_KEY1
                                                                     : osc_pkg::OSC_LK_IDLE;
            end
            osc_pkg::OSC_LK_KEY1: begin
              if (lane_wr[g] && lane_data[g] == KEY_SECOND) begin
                lock_next = osc_pkg::OSC_LK_OPEN;
              end else if (lane_wr[g] && lane_data[g] == KEY_FIRST) begin
                lock_next = osc_pkg::OSC_LK_KEY1; // Restarted sequence
              end else begin
                lock_next = osc_pkg::OSC_LK_IDLE;
              end
            end
            osc_pkg::OSC_LK_OPEN: begin
              lock_next = osc_pkg::OSC_LK_IDLE; // Window lasts one access only
            end
            default: begin
              lock_next = osc_pkg::OSC_LK_IDLE;
            end
          endcase
        end
      end

      // Sequencer register
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          lock_reg <= osc_pkg::OSC_LK_IDLE;
        end else begin
          lock_reg <= lock_next;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Control register next-state logic
  wire lo_wr_ok = lane_wr[0] & lane_open[0]; // Only inside the window
  wire hi_wr_ok = lane_wr[1] & lane_open[1];
  wire [7:0] lo_data = lane_data[0];
  wire [7:0] hi_data = lane_data[1];

  // Configuration decode: 1x disables both, 01 switching only, 00 both
  wire sw_en = ~config_reg[osc_pkg::OSC_CFG_SWMON_LSB + 1];
  wire failsafe_clock_monitor_en = (config_reg[osc_pkg::OSC_CFG_SWMON_LSB +: 2] == 2'b00);

  // Monitor events are ignored until the config word has been captured
  wire fail_evt = clock_fail_detect & failsafe_clock_monitor_en & cfg_loaded_reg;
  wire done_evt = req_reg & switch_done & ~fail_evt;

  wire [2:0] current_next = fail_evt ? osc_pkg::OSC_GRP_FAST_RC :
                            done_evt ? new_reg : current_reg;
  wire [2:0] new_next = hi_wr_ok ? hi_data[2:0] : new_reg;
  wire [1:0] post_next = lo_wr_ok ? lo_data[osc_pkg::OSC_POST_LSB +: 2] : post_reg;
  wire sec_en_next = lo_wr_ok ? lo_data[osc_pkg::OSC_SEC_EN_BIT] : sec_en_reg;

  // Software can only clear the flag; a failure in the same cycle wins
  wire cf_next = fail_evt | (lo_wr_ok ? (cf_reg & lo_data[osc_pkg::OSC_CF_BIT]) : cf_reg);

  // Request: failure clears, software sets or clears, completion clears.
  // With switching disabled a set is refused so the bit never sticks.
  logic req_next;
  always_comb begin
    if (fail_evt) begin
      req_next = 1'b0;
    end else if (lo_wr_ok) begin
      req_next = lo_data[osc_pkg::OSC_REQ_BIT] & sw_en;
    end else if (done_evt) begin
      req_next = 1'b0;
    end else begin
      req_next = req_reg;
    end
  end

  // Software clearing a live request aborts the transition
  wire abort_next = req_reg & ~req_next & ~done_evt & ~fail_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration capture and control register
  // The fuse word is a port, so it is caught on the first edge after release
  // rather than under the asynchronous reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_loaded_reg <= 1'b0;
      config_reg <= 24'h000000;
      current_reg <= osc_pkg::OSC_GRP_FAST_RC;
      new_reg <= osc_pkg::OSC_GRP_FAST_RC;
    end else if (!cfg_loaded_reg) begin
      cfg_loaded_reg <= 1'b1;
      config_reg <= cfg_fuse_word & osc_pkg::OSC_CFG_MASK;
      current_reg <= cfg_fuse_word[osc_pkg::OSC_CFG_GROUP_LSB +: 3];
      new_reg <= cfg_fuse_word[osc_pkg::OSC_CFG_GROUP_LSB +: 3];
    end else begin
      current_reg <= current_next;
      new_reg <= new_next;
    end
  end

  // Remaining control bits
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      post_reg <= osc_pkg::OSC_POST_RESET;
      cf_reg <= 1'b0;
      sec_en_reg <= 1'b0;
      req_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      post_reg <= post_next;
      cf_reg <= cf_next;
      sec_en_reg <= sec_en_next;
      req_reg <= req_next;
      abort_reg <= abort_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tuning register: unprotected, low byte lane carries the field
  wire trim_wr = wr_fire & hit_tune & wb_sel_i[0];
  wire [3:0] trim_next = trim_wr ? wb_dat_i[3:0] : trim_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_reg <= osc_pkg::OSC_TRIM_RESET;
    end else begin
      trim_reg <= trim_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Postscaler: free-running counter, one tick per divided period.
  // Shrinking the ratio mid-count wraps at the next terminal compare.
  wire [5:0] post_end = post_last(post_reg);
  wire post_wrap = (post_cnt_reg >= post_end);
  wire [5:0] post_cnt_next = post_wrap ? 6'h00 : post_cnt_reg + 6'h01;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      post_cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else begin
      post_cnt_reg <= post_cnt_next;
      tick_reg <= post_wrap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; unimplemented bits are built as zero
  wire [31:0] ctrl_view = {16'h0000, 1'b0, current_reg, 1'b0, new_reg, post_reg,
                           pll_locked, 1'b0, cf_reg, 1'b0, sec_en_reg, req_reg};
  wire [31:0] tune_view = {28'h0000000, trim_reg};
  wire [31:0] cfg_view = {8'h00, config_reg};
  wire [31:0] rdata_next = hit_ctrl ? ctrl_view :
                           hit_tune ? tune_view :
                           hit_cfg ? cfg_view : 32'h00000000; // Unmapped reads zero

  // Bus acknowledge: one cycle after the request, dropped the cycle after
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= access_fire;
      rdata_reg <= access_fire ? rdata_next : rdata_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign current_group = current_reg;
  assign switch_target = new_reg;
  assign switch_request = req_reg;
  assign switch_abort = abort_reg;
  assign clock_fail_flag = cf_reg;
  assign secondary_osc_enable = sec_en_reg;
  assign rc_trim_field = trim_reg;
  assign primary_option_config = config_reg[4:0];
  assign switch_enabled = sw_en;
  assign failsafe_clock_monitor = failsafe_clock_monitor_en;
  assign postscaled_tick = tick_reg;

endmodule

`default_nettype wire

//--- testbench.sv
// Self-checking bench for the oscillator select control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [7:0] CTL = osc_pkg::OSC_ADDR_CTRL; // Control word
  localparam logic [7:0] TUN = osc_pkg::OSC_ADDR_TUNE; // Trim word
  localparam logic [7:0] CFG = osc_pkg::OSC_ADDR_CFG; // Config snapshot
  logic sys_clk = 1'b0; // 200 MHz clock
  logic reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o; // Reset and bus controls
  logic pll_locked, clock_fail_detect, switch_done; // Analog side inputs
  logic [7:0] wb_adr_i; // Bus address
  logic [3:0] wb_sel_i, rc_trim_field; // Lanes, trim
  logic [31:0] wb_dat_i, wb_dat_o, rd; // Bus data, last read
  logic [23:0] cfg_fuse_word; // Configuration word
  logic [2:0] current_group, switch_target; // Group outputs
  logic [4:0] primary_option_config; // Primary option
  logic switch_request, switch_abort, clock_fail_flag, secondary_osc_enable; // Status outputs
  logic switch_enabled, failsafe_clock_monitor, postscaled_tick; // Decodes, tick
  int bad_count, checks, cycles, aborts, n; // Counters

  osc_select_ctrl i_osc_select_ctrl (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cfg_fuse_word, .pll_locked, .clock_fail_detect,
    .switch_done, .current_group, .switch_target, .switch_request, .switch_abort, .clock_fail_flag,
    .secondary_osc_enable, .rc_trim_field, .primary_option_config, .switch_enabled,
    .failsafe_clock_monitor, .postscaled_tick);

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout well beyond the roughly one thousand cycles the run needs; abort pulse tally
  always @(posedge sys_clk) begin
    cycles++;
    if (switch_abort === 1'b1) aborts++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One classic cycle, entered just after an edge; held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int w;
    w = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      w++;
    end while (wb_ack_o !== 1'b1 && w < 50);
    if (w >= 50) chk(1'b0, 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Key pair then the one allowed byte write, same lane throughout
  task automatic ctl(input logic hi, input logic [7:0] v);
    logic [3:0] s;
    s = hi ? 4'h2 : 4'h1;
    bus(1'b1, CTL, s, {4{hi ? osc_pkg::OSC_KEY_HI_FIRST : osc_pkg::OSC_KEY_LO_FIRST}});
    bus(1'b1, CTL, s, {4{hi ? osc_pkg::OSC_KEY_HI_SECOND : osc_pkg::OSC_KEY_LO_SECOND}});
    bus(1'b1, CTL, s, {4{v}});
  endtask

  // One-cycle pulse on done or on failure
  task automatic pulse(input logic fail);
    if (fail) clock_fail_detect <= 1'b1;
    else switch_done <= 1'b1;
    @(posedge sys_clk);
    clock_fail_detect <= 1'b0;
    switch_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset values, config snapshot, read-only and unmapped places
  task automatic t_reset();
    bus(1'b0, CFG, 4'hf, 32'h0);
    chk(rd, 32'h00000705);
    chk(primary_option_config, 5'h05);
    chk(failsafe_clock_monitor & switch_enabled, 1'b1);
    bus(1'b0, CTL, 4'hf, 32'h0);
    chk(rd, 32'h00007700);
    bus(1'b0, TUN, 4'hf, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, CFG, 4'hf, 32'h0);
    bus(1'b0, CFG, 4'hf, 32'h0);
    chk(rd, 32'h00000705);
    bus(1'b0, 8'h0c, 4'hf, 32'h0);
    chk(rd, 32'h0);
  endtask

  // Writes without a key, with a broken key pair, and after the window closed
  task automatic t_protect();
    bus(1'b1, CTL, 4'h3, 32'hffffffff);
    bus(1'b1, CTL, 4'h1, {4{osc_pkg::OSC_KEY_LO_FIRST}});
    bus(1'b0, TUN, 4'hf, 32'h0);
    bus(1'b1, CTL, 4'h1, {4{osc_pkg::OSC_KEY_LO_SECOND}});
    bus(1'b1, CTL, 4'h1, 32'hff);
    ctl(1'b0, 8'h00);
    bus(1'b1, CTL, 4'h1, 32'hff);
    bus(1'b0, CTL, 4'hf, 32'h0);
    chk(rd, 32'h00007700);
  endtask

  // Every postscaler code, secondary enable and lock bit
  task automatic t_post();
    for (int p = 0; p < 4; p++) begin
      pll_locked <= p[0];
      ctl(1'b0, {p[1:0], 4'h0, p[0], 1'b0});
      repeat (64) @(posedge sys_clk);
      n = 0;
      repeat (128) begin
        @(posedge sys_clk);
        n += postscaled_tick;
      end
      chk(n, 128 >> (2 * p));
      chk(secondary_osc_enable, p[0]);
      bus(1'b0, CTL, 4'hf, 32'h0);
      chk(rd[7:0], {p[1:0], p[0], 3'h0, p[0], 1'b0});
    end
  endtask

  // Switch, abort, then failure during a pending request
  task automatic t_switch();
    ctl(1'b1, 8'h01);
    chk(switch_target, 3'h1);
    ctl(1'b0, 8'h01);
    chk({switch_request, current_group}, 4'hf);
    pulse(1'b0);
    chk({switch_request, current_group}, 4'h1);
    ctl(1'b1, 8'h03);
    ctl(1'b0, 8'h01);
    ctl(1'b0, 8'h00);
    chk(aborts, 1);
    chk({switch_request, current_group}, 4'h1);
    ctl(1'b0, 8'h01);
    pulse(1'b0);
    chk(current_group, 3'h3);
    ctl(1'b0, 8'h01);
    pulse(1'b1);
    chk({clock_fail_flag, switch_request, current_group}, 5'h11);
    bus(1'b0, CTL, 4'hf, 32'h0);
    chk(rd, 32'h00001328);
    ctl(1'b0, 8'h08);
    chk(clock_fail_flag, 1'b1);
    ctl(1'b0, 8'h00);
    chk(clock_fail_flag, 1'b0);
  endtask

  // Trim field width and value
  task automatic t_trim();
    bus(1'b1, TUN, 4'hf, 32'hffffffff);
    bus(1'b0, TUN, 4'hf, 32'h0);
    chk(rd, 32'h0000000f);
    bus(1'b1, TUN, 4'h1, 32'h8);
    chk(rc_trim_field, 4'h8);
  endtask

  // Mid-run reset with switching and monitor disabled by the configuration word
  task automatic t_nosw();
    reset_n <= 1'b0;
    cfg_fuse_word <= 24'h008203;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(rc_trim_field, 4'h0);
    chk({switch_enabled, failsafe_clock_monitor}, 2'h0);
    bus(1'b0, CFG, 4'hf, 32'h0);
    chk(rd, 32'h00008203);
    ctl(1'b0, 8'h01);
    bus(1'b0, CTL, 4'hf, 32'h0);
    chk(rd, 32'h00002220);
    pulse(1'b1);
    chk({clock_fail_flag, switch_request, current_group}, 5'h02);
  endtask

  initial begin
    reset_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, pll_locked, clock_fail_detect, switch_done} = 6'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    cfg_fuse_word = 24'hff3f05;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_protect();
    t_post();
    t_switch();
    t_trim();
    t_nosw();
    print_verdict();
  end
endmodule

`default_nettype wire
